// file: hvib_pkg.sv
package hvib_pkg;
	// Register byte addresses
	localparam logic [31:0] HVIB_CMD_ADDR = 32'hFFFF0804;
	localparam logic [31:0] HVIB_DATA_ADDR = 32'hFFFF080C;
	// Command codes
	localparam logic [7:0] CMD_RD_CFG0 = 8'h00;
	localparam logic [7:0] CMD_RD_CFG1 = 8'h01;
	localparam logic [7:0] CMD_RD_STAT = 8'h02;
	localparam logic [7:0] CMD_RD_MON = 8'h03;
	localparam logic [7:0] CMD_WR_CFG0 = 8'h08;
	localparam logic [7:0] CMD_WR_CFG1 = 8'h09;
	// Command register read fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RDOK_BIT = 1;
	localparam int STAT_TXOK_BIT = 2;
	// Data register fields and reset values
	localparam int DATA_TAG_LSB = 8;
	localparam logic [11:0] DATA_RESET = 12'h000;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// Worst-case command latency in system cycles
	localparam int SYS_CLK_KHZ = 250000;
	localparam int LATENCY_US = 10;
	localparam int LAT_CYC = LATENCY_US * SYS_CLK_KHZ / 1000;
	localparam logic [11:0] LAT_LAST = 12'(LAT_CYC - 1);
	// Serial clock divider on the link clock
	localparam int LINK_CLK_KHZ = 12500;
	localparam int SCLK_KHZ = 2560;
	localparam int SCLK_HALF = LINK_CLK_KHZ / (2 * SCLK_KHZ);
	localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF - 1);
	// Frame bit positions
	localparam logic [4:0] FR_TURN = 5'h0D;
	localparam logic [4:0] FR_TXACK = 5'h0E;
	localparam logic [4:0] FR_RDATA = 5'h0F;
	localparam logic [4:0] FR_RDACK = 5'h17;
	// Link sequencer states
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_SEND = 2'b01,
		LK_HEAR = 2'b11,
		LK_DONE = 2'b10
	} hvib_link_state_t;
endpackage

// file: hvib_link.sv
`timescale 1ns/1ps
module hvib_link (
	input wire logic link_clk_i,
	input wire logic resetn_i,
	input wire logic req_tgl_i,
	input wire logic [3:0] cmd_i,
	input wire logic [7:0] wdata_i,
	output logic ack_tgl_o,
	output logic tx_ok_o,
	output logic rd_ok_o,
	output logic [7:0] rdata_o,
	output logic hv_sclk_o,
	input wire logic hv_sdata_i,
	output logic hv_sdata_o,
	output logic hv_sdata_oe_o
);
	import hvib_pkg::*;
	logic rst_meta_q, rst_n_q, req_meta_q, req_q, din_meta_q, din_q;
	logic sclk_q, is_rd_q;
	logic [2:0] div_q;
	logic [4:0] bit_q;
	logic [12:0] out_q;
	hvib_link_state_t st_q;
	logic bit_end;

	// Reset and request brought into the link domain
	always_ff @(posedge link_clk_i) begin
		rst_meta_q <= resetn_i;
		rst_n_q <= rst_meta_q;
	end
	always_ff @(posedge link_clk_i) begin
		if (!rst_n_q) begin
			req_meta_q <= 1'b0;
			req_q <= 1'b0;
			din_meta_q <= 1'b0;
			din_q <= 1'b0;
		end else begin
			req_meta_q <= req_tgl_i;
			req_q <= req_meta_q;
			din_meta_q <= hv_sdata_i;
			din_q <= din_meta_q;
		end
	end

	assign bit_end = (div_q == HALF_LAST) && sclk_q;
	assign hv_sclk_o = sclk_q;
	assign hv_sdata_o = out_q[12];

	// Frame sequencer: start, command nibble, byte, turnaround, answers
	always_ff @(posedge link_clk_i) begin
		if (!rst_n_q) begin
			st_q <= LK_IDLE;
			ack_tgl_o <= 1'b0;
			tx_ok_o <= 1'b0;
			rd_ok_o <= 1'b0;
			rdata_o <= 8'h00;
			sclk_q <= 1'b0;
			div_q <= 3'h0;
			bit_q <= 5'h00;
			out_q <= 13'h0000;
			is_rd_q <= 1'b0;
			hv_sdata_oe_o <= 1'b0;
		end else begin
			if (st_q != LK_IDLE) begin
				div_q <= (div_q == HALF_LAST) ? 3'h0 : div_q + 3'h1;
				if (div_q == HALF_LAST) sclk_q <= ~sclk_q;
			end
			unique case (st_q)
				LK_IDLE: if (req_q != ack_tgl_o) begin
					out_q <= {1'b1, cmd_i, wdata_i};
					is_rd_q <= ~cmd_i[3];
					bit_q <= 5'h00;
					div_q <= 3'h0;
					sclk_q <= 1'b0;
					hv_sdata_oe_o <= 1'b1;
					st_q <= LK_SEND;
				end
				LK_SEND: if (bit_end) begin
					out_q <= {out_q[11:0], 1'b0};
					bit_q <= bit_q + 5'h01;
					if (bit_q + 5'h01 == FR_TURN) begin
						hv_sdata_oe_o <= 1'b0;
						st_q <= LK_HEAR;
					end
				end
				LK_HEAR: if (bit_end) begin
					bit_q <= bit_q + 5'h01;
					if (bit_q == FR_TXACK) begin
						tx_ok_o <= din_q;
						rd_ok_o <= din_q;
						if (!is_rd_q) st_q <= LK_DONE;
					end
					if (bit_q >= FR_RDATA && bit_q < FR_RDACK) rdata_o <= {rdata_o[6:0], din_q};
					if (bit_q == FR_RDACK) begin
						rd_ok_o <= din_q;
						st_q <= LK_DONE;
					end
				end
				LK_DONE: begin
					sclk_q <= 1'b0;
					ack_tgl_o <= ~ack_tgl_o;
					st_q <= LK_IDLE;
				end
			endcase
		end
	end
endmodule

// file: hvib_bridge.sv
`timescale 1ns/1ps
module hvib_bridge (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic link_clk_i,
	input wire logic [31:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic [7:0] hv_config_zero_o,
	output logic [7:0] hv_config_one_o,
	output logic hv_sclk_o,
	input wire logic hv_sdata_i,
	output logic hv_sdata_o,
	output logic hv_sdata_oe_o
);
	import hvib_pkg::*;

	logic busy_q;
	logic wait_link_q;
	logic bad_q;
	logic req_tgl_q;
	logic [3:0] cmd_q;
	logic tx_ok_q;
	logic rd_ok_q;
	logic [11:0] data_q;
	logic [7:0] cfg0_q;
	logic [7:0] cfg1_q;
	logic [11:0] wd_cnt_q;
	logic ack_meta_q;
	logic ack_sync_q;
	logic lk_ack;
	logic lk_tx_ok;
	logic lk_rd_ok;
	logic [7:0] lk_rdata;
	logic wr_cmd;
	logic wr_data;
	logic rd_cmd;
	logic rd_data;
	logic [7:0] cmd_code;
	logic [3:0] cmd_nib;
	logic [7:0] data_byte;
	logic cmd_ok;
	logic start;
	logic link_done;
	logic timeout;

	// Address decode on the register port
	assign wr_cmd = reg_wr_i && (reg_addr_i == HVIB_CMD_ADDR);
	assign wr_data = reg_wr_i && (reg_addr_i == HVIB_DATA_ADDR);
	assign rd_cmd = reg_rd_i && (reg_addr_i == HVIB_CMD_ADDR);
	assign rd_data = reg_rd_i && (reg_addr_i == HVIB_DATA_ADDR);
	assign cmd_code = reg_wdata_i[7:0];
	assign cmd_nib = reg_wdata_i[3:0];
	assign data_byte = data_q[7:0];

	// Only six codes start a link transfer
	always_comb begin
		unique case (cmd_code)
			CMD_RD_CFG0, CMD_RD_CFG1, CMD_RD_STAT, CMD_RD_MON,
			CMD_WR_CFG0, CMD_WR_CFG1: cmd_ok = 1'b1;
			default: cmd_ok = 1'b0;
		endcase
	end

	// Commands while busy are dropped to keep link words stable
	assign start = wr_cmd && !busy_q;
	assign link_done = wait_link_q && (ack_sync_q == req_tgl_q);
	assign timeout = wait_link_q && !link_done && (wd_cnt_q == LAT_LAST);

	// Completion toggle back from the link domain
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ack_meta_q <= 1'b0;
			ack_sync_q <= 1'b0;
		end else begin
			ack_meta_q <= lk_ack;
			ack_sync_q <= ack_meta_q;
		end
	end

	// Busy and link request handshake
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			busy_q <= 1'b0;
			wait_link_q <= 1'b0;
			bad_q <= 1'b0;
			req_tgl_q <= 1'b0;
			cmd_q <= 4'h0;
		end else if (start) begin
			busy_q <= 1'b1;
			cmd_q <= cmd_nib;
			if (cmd_ok) begin
				wait_link_q <= 1'b1;
				req_tgl_q <= ~req_tgl_q;
			end else begin
				bad_q <= 1'b1;
			end
		end else if (bad_q || link_done || timeout) begin
			busy_q <= 1'b0;
			wait_link_q <= 1'b0;
			bad_q <= 1'b0;
		end
	end

	// Watchdog bounds the wait for the far die
	always_ff @(posedge clk_i) begin
		if (!resetn_i || !wait_link_q) begin
			wd_cnt_q <= 12'h000;
		end else if (wd_cnt_q != LAT_LAST) begin
			wd_cnt_q <= wd_cnt_q + 12'h001;
		end
	end

	// Pass and fail flags, updated only when busy falls
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tx_ok_q <= 1'b0;
			rd_ok_q <= 1'b0;
		end else if (link_done) begin
			tx_ok_q <= lk_tx_ok;
			rd_ok_q <= lk_rd_ok;
		end else if (bad_q || timeout) begin
			tx_ok_q <= 1'b0;
			rd_ok_q <= 1'b0;
		end
	end

	// Data register: software byte, command tag, returned byte
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			data_q <= DATA_RESET;
		end else if (start) begin
			data_q[11:DATA_TAG_LSB] <= cmd_nib;
		end else if (link_done && !cmd_q[3] && lk_rd_ok) begin
			data_q[7:0] <= lk_rdata;
		end else if (wr_data && !busy_q) begin
			data_q[7:0] <= reg_wdata_i[7:0];
		end
	end

	// Config copies follow acknowledged writes
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cfg0_q <= CFG_RESET;
			cfg1_q <= CFG_RESET;
		end else if (link_done && lk_tx_ok) begin
			if (cmd_q == CMD_WR_CFG0[3:0]) cfg0_q <= data_byte;
			if (cmd_q == CMD_WR_CFG1[3:0]) cfg1_q <= data_byte;
		end
	end
	assign hv_config_zero_o = cfg0_q;
	assign hv_config_one_o = cfg1_q;

	// Registered read port; configs have no address
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (rd_cmd) begin
			reg_rdata_o <= 32'h0000_0000;
			reg_rdata_o[STAT_BUSY_BIT] <= busy_q;
			reg_rdata_o[STAT_RDOK_BIT] <= rd_ok_q;
			reg_rdata_o[STAT_TXOK_BIT] <= tx_ok_q;
		end else if (rd_data) begin
			reg_rdata_o <= {20'h00000, data_q};
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	// Serial engine on the link clock
	hvib_link u_link (
		.link_clk_i(link_clk_i),
		.resetn_i(resetn_i),
		.req_tgl_i(req_tgl_q),
		.cmd_i(cmd_q),
		.wdata_i(data_byte),
		.ack_tgl_o(lk_ack),
		.tx_ok_o(lk_tx_ok),
		.rd_ok_o(lk_rd_ok),
		.rdata_o(lk_rdata),
		.hv_sclk_o(hv_sclk_o),
		.hv_sdata_i(hv_sdata_i),
		.hv_sdata_o(hv_sdata_o),
		.hv_sdata_oe_o(hv_sdata_oe_o)
	);

	// Checks on the system clock
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_start_bad;
		start && !cmd_ok;
	endsequence

	sequence s_bad_retire;
		busy_q ##1 (!busy_q && !tx_ok_q && !rd_ok_q);
	endsequence

	sequence s_write_done;
		link_done && lk_tx_ok && (cmd_q == CMD_WR_CFG0[3:0]);
	endsequence

	AST_BUSY_SET: assert property (start |=> busy_q)
		else $error("busy not set after command");

	AST_TAG_LOAD: assert property (start |=> data_q[11:8] == $past(cmd_nib))
		else $error("data tag does not match command");

	AST_BAD_CMD: assert property (s_start_bad |=> s_bad_retire)
		else $error("undefined command not retired as failed");

	AST_BAD_NO_LINK: assert property (s_start_bad |=> !wait_link_q && $stable(req_tgl_q))
		else $error("undefined command reached the link");

	AST_WD_BOUND: assert property (wait_link_q |-> wd_cnt_q <= LAT_LAST)
		else $error("command wait exceeded latency bound");

	AST_BUSY_FALL: assert property (timeout |=> !busy_q && !tx_ok_q)
		else $error("timeout did not end command");

	AST_READ_LOAD: assert property
		(link_done && !cmd_q[3] && lk_rd_ok |=> data_q[7:0] == $past(lk_rdata))
		else $error("read-back byte not loaded");

	AST_CFG0_WRITE: assert property (s_write_done |=> cfg0_q == $past(data_byte))
		else $error("config zero not updated");

	AST_STAT_READ: assert property (rd_cmd |=> reg_rdata_o[0] == $past(busy_q))
		else $error("busy bit readback wrong");

	AST_FLAGS_IDLE: assert property
		(!busy_q && !$past(busy_q) |-> $stable(tx_ok_q) && $stable(rd_ok_q))
		else $error("status flags changed while idle");

	AST_IGNORE_BUSY: assert property (wr_cmd && busy_q |=> $stable(req_tgl_q))
		else $error("command taken while busy");
endmodule

// file: hvib_die_model.sv
`timescale 1ns/1ps
// Behavioural far-side die: four indirect registers behind the two-wire link
module hvib_die_model #(
	parameter logic [7:0] STAT_VAL = 8'h5A,
	parameter logic [7:0] MON_VAL = 8'hC3
) (
	input wire logic link_clk_i,
	input wire logic hv_sclk_i,
	input wire logic dev_d_i,
	input wire logic dev_oe_i,
	input wire logic nack_i,
	output logic line_o,
	output logic [7:0] cfg0_o,
	output logic [7:0] cfg1_o
);
	logic [4:0] cnt = 5'h00;
	logic [12:0] fr = 13'h0000;
	logic die_oe = 1'b0;
	logic die_d = 1'b0;
	logic junk = 1'b0;
	logic [7:0] rbyte;
	initial cfg0_o = 8'h00;
	initial cfg1_o = 8'h00;
	// Undriven line wanders so a stale value never passes
	always @(posedge link_clk_i) junk <= ~junk;
	assign line_o = dev_oe_i ? dev_d_i : (die_oe ? die_d : junk);
	always_comb begin
		case (fr[9:8])
			2'b00: rbyte = cfg0_o;
			2'b01: rbyte = cfg1_o;
			2'b10: rbyte = STAT_VAL;
			default: rbyte = MON_VAL;
		endcase
	end
	// Capture start, command and data on rising serial clock
	always @(posedge hv_sclk_i) begin
		if (cnt < 5'd13) fr = {fr[11:0], line_o};
		if (cnt == 5'd12 && !nack_i && fr[11]) begin
			if (fr[8]) cfg1_o = fr[7:0];
			else cfg0_o = fr[7:0];
		end
		cnt = cnt + 5'd1;
	end
	// Answer just after the falling serial clock
	always @(negedge hv_sclk_i) begin
		die_oe = 1'b0;
		if (cnt == 5'd14 || (!fr[11] && cnt == 5'd23)) begin
			die_oe = 1'b1;
			die_d = ~nack_i;
		end else if (!fr[11] && cnt >= 5'd15 && cnt <= 5'd22) begin
			die_oe = 1'b1;
			die_d = rbyte[5'd22 - cnt];
		end
		if (cnt == (fr[11] ? 5'd15 : 5'd24)) cnt = 5'h00;
	end
endmodule

// file: hv_indirect_register_bridge_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
module hv_indirect_register_bridge_tb;
	import hvib_pkg::*;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic resetn = 1'b0;
	logic [31:0] addr = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [7:0] cfg0, cfg1, m_cfg0, m_cfg1;
	logic sclk, sd_o, sd_oe, line;
	logic nack = 1'b0;
	int n_fail = 0;
	int checked = 0;
	logic [31:0] r;
	logic [7:0] exp_b [4] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3};
	always #2 clk = ~clk;
	initial begin
		#13;
		forever #40 link_clk = ~link_clk;
	end
	hvib_bridge uut (.clk_i(clk), .resetn_i(resetn), .link_clk_i(link_clk),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .hv_config_zero_o(cfg0), .hv_config_one_o(cfg1),
		.hv_sclk_o(sclk), .hv_sdata_i(line), .hv_sdata_o(sd_o), .hv_sdata_oe_o(sd_oe));
	hvib_die_model die (.link_clk_i(link_clk), .hv_sclk_i(sclk), .dev_d_i(sd_o),
		.dev_oe_i(sd_oe), .nack_i(nack), .line_o(line), .cfg0_o(m_cfg0), .cfg1_o(m_cfg1));
	task automatic test_done();
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = {24'h000000, d};
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		d = rdata;
		rd = 1'b0;
	endtask
	// Load data, issue a command, poll to completion, judge flags and data
	task automatic run_cmd(input logic [7:0] c, input logic [7:0] d, input logic [2:0] st,
		input logic [31:0] exp_d, input logic chk_busy, input logic chk_dat);
		realtime t0;
		int k;
		reg_wr(HVIB_DATA_ADDR, d);
		reg_wr(HVIB_CMD_ADDR, c);
		t0 = $realtime;
		reg_rd(HVIB_CMD_ADDR, r);
		if (chk_busy) `CHK(r[0], 1'b1)
		// Writes while busy must leave the running command and its byte alone
		if (chk_busy) begin
			reg_wr(HVIB_DATA_ADDR, 8'h00);
			reg_wr(HVIB_CMD_ADDR, CMD_RD_STAT);
		end
		for (k = 0; k < 1000 && r[0] !== 1'b0; k++) reg_rd(HVIB_CMD_ADDR, r);
		if (r[0] !== 1'b0) begin
			`CHK(r[0], 1'b0)
			test_done();
		end
		`CHK($realtime - t0 <= 10000.0, 1'b1)
		`CHK(r[7:0], {5'h00, st})
		reg_rd(HVIB_DATA_ADDR, r);
		if (chk_dat) `CHK(r, exp_d)
	endtask
	initial begin
		repeat (100) @(negedge clk);
		resetn = 1'b1;
		repeat (100) @(negedge clk);
		reg_rd(HVIB_DATA_ADDR, r);
		`CHK(r, {20'h00000, DATA_RESET})
		`CHK(cfg0, CFG_RESET)
		run_cmd(CMD_WR_CFG0, 8'hA5, 3'b110, 32'h8A5, 1'b1, 1'b1);
		`CHK(cfg0, 8'hA5)
		`CHK(m_cfg0, 8'hA5)
		run_cmd(CMD_WR_CFG1, 8'h3C, 3'b110, 32'h93C, 1'b1, 1'b1);
		`CHK(cfg1, 8'h3C)
		for (int i = 0; i < 4; i++) run_cmd(8'(i), 8'hFF, 3'b110,
			{20'h00000, 4'(i), exp_b[i]}, 1'b1, 1'b1);
		run_cmd(8'h05, 8'h77, 3'b000, 32'h577, 1'b0, 1'b1);
		`CHK({cfg0, cfg1}, 16'hA53C)
		nack = 1'b1;
		run_cmd(CMD_WR_CFG0, 8'h11, 3'b000, 32'h0, 1'b1, 1'b0);
		`CHK(cfg0, 8'hA5)
		nack = 1'b0;
		reg_rd(32'hFFFF0808, r);
		`CHK(r, 32'h00000000)
		test_done();
	end
endmodule
